// *** src/adc_refhit.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_refhit
    import adc_refhit_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // converter events, one bit per result channel
    input wire logic [hit_channels-1:0] buf_written,
    input wire logic [hit_channels-1:0] match,
    // analog controls
    output logic half_bandgap_enable,
    output logic full_bandgap_enable,
    output logic [1:0] compare_mode_field,
    // interrupt
    output logic irq
);
    logic wr_en;
    logic rd_en;
    logic [7:0] acc_addr;
    logic [15:0] ref_r;
    logic [15:0] ref_nxt;
    logic [2:0] mode_r;
    logic [2:0] mode_nxt;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_stat_nxt;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_mask_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [15:0] hit_mask;
    logic [15:0] hit_word;
    logic [hit_channels-1:0] flags;
    logic [hit_channels-1:0] set_ev;
    logic hit_wr;
    logic ref_wr;
    logic small_pkg;

    // --------------------------------------------------------------
    // bus slave
    // --------------------------------------------------------------
    ahb_word_slave u_slave (
        .clk(clk),
        .rst_b(rst_b),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .addr(acc_addr)
    );

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hit_wr = wr_en & (acc_addr == hit_low_addr);
    assign ref_wr = wr_en & (acc_addr == ref_config_addr);
    assign small_pkg = mode_r[small_pkg_bit];
    assign hit_mask = small_pkg ? hit_mask_small : hit_mask_large;

    // --------------------------------------------------------------
    // compare hit flags
    // --------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < hit_channels; gi++)
        begin : g_hit
            hit_flag_cell u_cell (
                .clk(clk),
                .rst_b(rst_b),
                .present(hit_mask[gi]),
                .buffer_mode(mode_r[1:0] == mode_buffer_or_match),
                .buf_written(buf_written[gi]),
                .match(match[gi]),
                .sw_write(hit_wr),
                .sw_data(hwdata[gi]),
                .flag(flags[gi]),
                .set_event(set_ev[gi])
            );
        end
    endgenerate

    assign hit_word = {3'h0, flags} & hit_mask;

    // --------------------------------------------------------------
    // control registers
    // --------------------------------------------------------------
    always_comb
    begin
        ref_nxt = ref_r;
        mode_nxt = mode_r;
        irq_mask_nxt = irq_mask_r;
        irq_stat_nxt = irq_stat_r;
        if (ref_wr)
        begin
            ref_nxt = hwdata[15:0] & ref_config_mask;
        end
        if (wr_en && acc_addr == mode_ctrl_addr)
        begin
            mode_nxt = hwdata[2:0];
        end
        if (wr_en && acc_addr == irq_mask_addr)
        begin
            irq_mask_nxt = hwdata[1:0];
        end
        if (rd_en && acc_addr == irq_status_addr)
        begin
            irq_stat_nxt = 2'h0;
        end
        // set wins over read clear
        if (|set_ev)
        begin
            irq_stat_nxt[irq_hit_bit] = 1'b1;
        end
        if (ref_wr && ((hwdata[15:0] & ref_config_mask) != ref_r))
        begin
            irq_stat_nxt[irq_ref_bit] = 1'b1;
        end
    end

    // --------------------------------------------------------------
    // read data
    // --------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        unique case (acc_addr)
            ref_config_addr: rdata_nxt = {16'h0000, ref_r & ref_config_mask};
            hit_low_addr: rdata_nxt = {16'h0000, hit_word};
            mode_ctrl_addr: rdata_nxt = {29'h0, mode_r};
            irq_status_addr: rdata_nxt = {30'h0, irq_stat_r};
            irq_mask_addr: rdata_nxt = {30'h0, irq_mask_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ref_r <= ref_config_reset;
            mode_r <= {1'b0, mode_reset};
            irq_stat_r <= irq_reset;
            irq_mask_r <= irq_reset;
        end
        else
        begin
            ref_r <= ref_nxt;
            mode_r <= mode_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    assign rdata_r = rdata_nxt;
    assign hrdata = rdata_r;
    assign half_bandgap_enable = ref_r[half_bg_bit];
    assign full_bandgap_enable = ref_r[full_bg_bit];
    assign compare_mode_field = mode_r[1:0];
    assign irq = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

// *** src/adc_refhit_pkg.sv ***
package adc_refhit_pkg;

    // --------------------------------------------------------------
    // register map (byte addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] ref_config_addr = 8'h00;
    localparam logic [7:0] hit_low_addr = 8'h04;
    localparam logic [7:0] mode_ctrl_addr = 8'h08;
    localparam logic [7:0] irq_status_addr = 8'h0c;
    localparam logic [7:0] irq_mask_addr = 8'h10;

    // --------------------------------------------------------------
    // field layout and reset values
    // --------------------------------------------------------------
    localparam int full_bg_bit = 0;
    localparam int half_bg_bit = 1;
    localparam logic [15:0] ref_config_mask = 16'h0003;
    localparam logic [15:0] ref_config_reset = 16'h0000;
    localparam int hit_channels = 13;
    localparam logic [15:0] hit_mask_large = 16'h1eff;
    localparam logic [15:0] hit_mask_small = 16'h02ff;
    localparam logic [15:0] hit_reset = 16'h0000;
    localparam logic [1:0] mode_buffer_or_match = 2'h3;
    localparam logic [1:0] mode_reset = 2'h0;
    localparam int small_pkg_bit = 2;
    localparam logic [1:0] irq_reset = 2'h0;
    localparam int irq_hit_bit = 0;
    localparam int irq_ref_bit = 1;

    typedef enum logic [1:0] {
        htrans_idle = 2'h0,
        htrans_busy = 2'h1,
        htrans_nonseq = 2'h2,
        htrans_seq = 2'h3
    } htrans_t;

endpackage

// *** src/hit_flag_cell.sv ***
`timescale 1ns/1ns
`default_nettype none
module hit_flag_cell
    import adc_refhit_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic present,
    input wire logic buffer_mode,
    input wire logic buf_written,
    input wire logic match,
    input wire logic sw_write,
    input wire logic sw_data,
    // state
    output logic flag,
    output logic set_event
);
    logic flag_r;
    logic flag_nxt;
    logic set_now;

    always_comb
    begin
        if (buffer_mode)
        begin
            set_now = buf_written | match;
        end
        else
        begin
            set_now = match;
        end
        set_now = set_now & present;
        flag_nxt = flag_r;
        if (sw_write)
        begin
            flag_nxt = sw_data & present;
        end
        if (set_now)
        begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flag_r <= 1'b0;
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;
    assign set_event = set_now & ~flag_r;
endmodule
`default_nettype wire

// *** src/ahb_word_slave.sv ***
`timescale 1ns/1ns
`default_nettype none
module ahb_word_slave
    import adc_refhit_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // ahb address phase
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    // decoded data phase
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr
);
    logic wr_r;
    logic wr_nxt;
    logic rd_r;
    logic rd_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic take;

    always_comb
    begin
        take = hsel & hready & htrans[1];
        wr_nxt = take & hwrite;
        rd_nxt = take & ~hwrite;
        addr_nxt = take ? haddr : addr_r;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= 8'h00;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            addr_r <= addr_nxt;
        end
    end

    assign wr_en = wr_r;
    assign rd_en = rd_r;
    assign addr = addr_r;
endmodule
`default_nettype wire

// *** test/adc_refhit_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_refhit_monitor
    import adc_refhit_pkg::*;
(
    // bus
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // controls
    input wire logic half_bandgap_enable,
    input wire logic full_bandgap_enable,
    input wire logic [1:0] compare_mode_field
);
    logic wr_ref;
    assign wr_ref = hsel && hready && htrans[1] && hwrite && haddr == ref_config_addr;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_acc(logic w, logic [7:0] a);
        hsel && hready && htrans[1] && hwrite == w && haddr == a;
    endsequence
    sequence s_wr(logic [7:0] a);
        s_acc(1'b1, a) ##1 1'b1;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error");
    a_full_write: assert property (
        s_wr(ref_config_addr) |=> full_bandgap_enable == $past(hwdata[0]))
        else $error("full enable not written");
    a_half_write: assert property (
        s_wr(ref_config_addr) |=> half_bandgap_enable == $past(hwdata[1]))
        else $error("half enable not written");
    a_ref_hold: assert property (
        $changed({half_bandgap_enable, full_bandgap_enable}) |-> $past(wr_ref, 2))
        else $error("enable moved without write");
    a_ref_read: assert property (
        s_acc(1'b0, ref_config_addr)
        |=> hrdata == {30'h0, half_bandgap_enable, full_bandgap_enable})
        else $error("ref config read wrong");
    a_hit_zeros: assert property (
        s_acc(1'b0, hit_low_addr) |=> hrdata[31:13] == 19'h0 && !hrdata[8])
        else $error("hit unused bits set");
    a_mode_write: assert property (
        s_wr(mode_ctrl_addr) |=> compare_mode_field == $past(hwdata[1:0]))
        else $error("mode not written");
    a_reset_clear: assert property (
        $rose(rst_b) |-> !half_bandgap_enable && !full_bandgap_enable)
        else $error("enable set after reset");
    a_unmapped_zero: assert property (s_acc(1'b0, 8'h14) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind adc_refhit adc_refhit_monitor u_mon (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .half_bandgap_enable, .full_bandgap_enable,
    .compare_mode_field);
`default_nettype wire

// *** test/tb_adc_refhit.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_adc_refhit
    import adc_refhit_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq, hb, fb;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0, cm;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic [12:0] buf_written = 13'h0, match = 13'h0;
    int n_fail = 0, n_tests = 0;
    initial forever #25 clk = ~clk;
    adc_refhit u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .buf_written(buf_written), .match(match),
        .half_bandgap_enable(hb), .full_bandgap_enable(fb), .compare_mode_field(cm), .irq(irq));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // one bus phase, held until hready seen high
    task automatic beat;
        logic r;
        do
        begin
            @(negedge clk);
            r = hreadyout;
            q = hrdata;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= htrans_nonseq;
        hwrite <= w;
        beat;
        hsel <= 1'b0;
        htrans <= htrans_idle;
        hwdata <= d;
        beat;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic pulse(input logic [12:0] b, input logic [12:0] m);
        buf_written <= b;
        match <= m;
        @(posedge clk);
        buf_written <= 13'h0;
        match <= 13'h0;
        @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_reset;
        logic [7:0] regs[6] = '{ref_config_addr, hit_low_addr, mode_ctrl_addr,
            irq_status_addr, irq_mask_addr, 8'h14};
        foreach (regs[i]) rdchk("reset", regs[i], 32'h0);
        bus(8'h14, 1'b1, 32'hffffffff);
        rdchk("unmapped", 8'h14, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_ref;
        bus(ref_config_addr, 1'b1, 32'hffffffff);
        rdchk("ref", ref_config_addr, 32'h3);
        chk("enables", 32'h3, {30'h0, hb, fb});
        bus(ref_config_addr, 1'b1, 32'h1);
        rdchk("ref", ref_config_addr, 32'h1);
        chk("enables", 32'h1, {30'h0, hb, fb});
        $display("t_ref done");
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++)
        begin
            bus(mode_ctrl_addr, 1'b1, 32'(m));
            bus(hit_low_addr, 1'b1, 32'h0);
            rdchk("cleared", hit_low_addr, 32'h0);
            pulse(13'h1fff, 13'h0);
            rdchk("buffer", hit_low_addr, m == 3 ? 32'h1eff : 32'h0);
            pulse(13'h0, 13'h1fff);
            rdchk("match", hit_low_addr, 32'h1eff);
            rdchk("sticky", hit_low_addr, 32'h1eff);
            chk("mode", 32'(m), {30'h0, cm});
        end
        bus(hit_low_addr, 1'b1, 32'hffff);
        rdchk("sw set", hit_low_addr, 32'h1eff);
        $display("t_modes done");
    endtask
    task automatic t_small;
        bus(mode_ctrl_addr, 1'b1, 32'h4);
        bus(hit_low_addr, 1'b1, 32'h0);
        pulse(13'h0, 13'h1fff);
        rdchk("small", hit_low_addr, 32'h02ff);
        bus(mode_ctrl_addr, 1'b1, 32'h0);
        $display("t_small done");
    endtask
    task automatic t_irq;
        bus(hit_low_addr, 1'b1, 32'h0);
        bus(irq_mask_addr, 1'b1, 32'h1);
        bus(irq_status_addr, 1'b0, 32'h0);
        pulse(13'h0, 13'h1);
        @(negedge clk);
        chk("irq", 32'h1, 32'(irq));
        @(posedge clk);
        rdchk("status", irq_status_addr, 32'h1);
        @(negedge clk);
        chk("irq", 32'h0, 32'(irq));
        @(posedge clk);
        bus(irq_mask_addr, 1'b1, 32'h0);
        pulse(13'h0, 13'h2);
        @(negedge clk);
        chk("masked", 32'h0, 32'(irq));
        @(posedge clk);
        rdchk("status", irq_status_addr, 32'h1);
        bus(irq_mask_addr, 1'b1, 32'h2);
        bus(ref_config_addr, 1'b1, 32'h2);
        @(negedge clk);
        chk("irq ref", 32'h1, 32'(irq));
        @(posedge clk);
        rdchk("status", irq_status_addr, 32'h2);
        $display("t_irq done");
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_ref;
        t_modes;
        t_small;
        t_irq;
        give_verdict;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        give_verdict;
    end
endmodule
`default_nettype wire
